// file: bench/carkit_control_registers_chk.sv
`timescale 1ns/1ps
module carkit_control_registers_chk #(
    parameter int CONVERT_CYCLES = carkit_pkg::CONVERT_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [5:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    input  wire logic       ulpi_data0_i,
    input  wire logic       id_pin_floating_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic       reg_rvalid_o,
    input  wire logic       id_pin_ground_drive_b_o,
    input  wire logic       minus_line_data_o,
    input  wire logic       ulpi_data1_o,
    input  wire logic       left_speaker_switch_o,
    input  wire logic       right_speaker_switch_o,
    input  wire logic       single_ended_rx_enable_o,
    input  wire logic       alt_int_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic ctl_wr;
    // A load at the base sets every writable bit, so outputs two edges on are fully known
    assign ctl_wr = reg_write_i && reg_addr_i == 6'h19;

    a_read_answer_pulse: assert property (reg_read_i |=> reg_rvalid_o) else $error("read not answered");
    a_rvalid_has_cause: assert property (reg_rvalid_o |-> $past(reg_read_i)) else $error("stray rvalid");
    a_id_ground_drive: assert property (ctl_wr |=> ##1
        id_pin_ground_drive_b_o == !$past(reg_wdata_i[1], 2)) else $error("ground drive wrong");
    a_data1_held_high: assert property (ctl_wr && !reg_wdata_i[3] |=> ##1 ulpi_data1_o) else $error("data1 low");
    a_minus_tx_route: assert property (ctl_wr && reg_wdata_i[2] |=> ##1
        minus_line_data_o == $past(ulpi_data0_i)) else $error("transmit route wrong");
    a_right_switch_or: assert property (ctl_wr |=> ##1
        right_speaker_switch_o == ($past(reg_wdata_i[5], 2) | $past(reg_wdata_i[6], 2))) else $error("right switch");
    a_se_rx_disable: assert property (ctl_wr |=> ##1
        single_ended_rx_enable_o == !(|$past(reg_wdata_i[6:4], 2))) else $error("receiver enable wrong");
    a_enable_zero_bits: assert property (reg_read_i && reg_addr_i inside {[6'h1d:6'h1f]} |=>
        reg_rdata_o[4:2] == 3'b000 && reg_rdata_o[7:6] == 2'b00) else $error("enable reserved bits");
    a_status_zero_bits: assert property (reg_read_i && reg_addr_i == 6'h20 |=>
        reg_rdata_o[7] == 1'b0 && reg_rdata_o[2:1] == 2'b00) else $error("status reserved bits");
    a_status_float_bit: assert property (reg_read_i && reg_addr_i == 6'h20 |=>
        reg_rdata_o[0] == $past(id_pin_floating_i, 2)) else $error("float status wrong");
    a_scratch_no_effect: assert property (reg_write_i && reg_addr_i inside {[6'h16:6'h18]} |=> ##1
        $stable({id_pin_ground_drive_b_o, left_speaker_switch_o, right_speaker_switch_o})) else $error("scratch leak");

    c_event: cover property (alt_int_o);
    c_status_read: cover property (reg_read_i && reg_addr_i == 6'h20);
    c_audio_on: cover property (ctl_wr ##2 !single_ended_rx_enable_o);
endmodule

bind carkit_control_registers carkit_control_registers_chk #(.CONVERT_CYCLES(CONVERT_CYCLES)) u_chk (
    .clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .ulpi_data0_i, .id_pin_floating_i,
    .reg_rdata_o, .reg_rvalid_o, .id_pin_ground_drive_b_o, .minus_line_data_o, .ulpi_data1_o,
    .left_speaker_switch_o, .right_speaker_switch_o, .single_ended_rx_enable_o, .alt_int_o);

// file: bench/carkit_control_registers_test.sv
`timescale 1ns/1ps
module carkit_control_registers_test;
    localparam int CYC = 8;
    logic       clk, rst_b, vend, data0, plus, flt, rvalid, wr, rd, mode;
    logic [2:0] sense;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, d, ctl, scr, b;
    logic       gnd, mdrv, mdat, d1, lsw, rsw, lpin, rpin, se, alt;
    int         errors, cmp_count, cycles, alt_cnt, seed, i, k, n;
    logic [5:0] regs [5] = '{6'h16, 6'h19, 6'h1d, 6'h20, 6'h36};
    logic [5:0] tbl [4] = '{6'h19, 6'h1d, 6'h20, 6'h3f};
    logic [7:0] texp [4] = '{8'h7e, 8'h23, 8'h00, 8'h00};
    logic [7:0] fen [5] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h00};
    logic       fexp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

    carkit_control_registers #(.CONVERT_CYCLES(CYC)) u_carkit_control_registers (
        .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
        .accessory_mode_select_i(mode), .vendor_done_event_enable_i(vend), .ulpi_data0_i(data0),
        .plus_line_i(plus), .id_pin_floating_i(flt), .id_resistor_sense_i(sense), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .id_pin_ground_drive_b_o(gnd), .minus_line_drive_b_o(mdrv), .minus_line_data_o(mdat),
        .ulpi_data1_o(d1), .left_speaker_switch_o(lsw), .right_speaker_switch_o(rsw), .left_speaker_pin_o(lpin),
        .right_speaker_pin_o(rpin), .single_ended_rx_enable_o(se), .alt_int_o(alt));
    link_model u_link_model (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .write_o(wr), .read_o(rd), .mode_o(mode));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (alt === 1'b1) alt_cnt++;
        if (cycles == 6000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check1(input string nm, input logic e, input logic g);
        check8(nm, {7'h00, e}, {7'h00, g});
    endtask
    function automatic logic [7:0] apply(input int op, input logic [7:0] o, input logic [7:0] v, input logic [7:0] m);
        return op == 0 ? v & m : op == 1 ? o | (v & m) : o & ~(v & m);
    endfunction
    task automatic chk_out();
        check1("ground", ~ctl[1], gnd);
        check1("minus_drive", ~(mode & ctl[2]), mdrv);
        check1("minus_data", ctl[2] & data0, mdat);
        check1("data1", ctl[3] ? plus : 1'b1, d1);
        check1("left_switch", ctl[4], lsw);
        check1("right_switch", ctl[5] | ctl[6], rsw);
        check1("left_pin", mode & ctl[2] & ctl[4] & data0, lpin);
        check1("right_pin", mode & ctl[3] & (ctl[5] | ctl[6]) & plus, rpin);
        check1("se_rx", ~|ctl[6:4], se);
    endtask

    initial begin
        seed = 78616;
        {rst_b, vend, data0, plus, flt, sense} = '0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        for (i = 0; i < 5; i++) begin
            u_link_model.rd(regs[i], d);
            check8("reset", 8'h00, d);
        end
        {scr, ctl} = '0;
        for (i = 0; i < 60; i++) begin
            k = $unsigned($random(seed)) % 3;
            b = 8'($random(seed));
            {data0, plus} = 2'($random(seed));
            u_link_model.wr(regs[i % 2] + 6'(k), b);
            scr = (i % 2 == 0) ? apply(k, scr, b, 8'hff) : scr;
            ctl = (i % 2 == 1) ? apply(k, ctl, b, 8'h7e) : ctl;
            u_link_model.rd(regs[i % 2] + 6'($unsigned($random(seed)) % 3), d);
            check8("readback", (i % 2 == 0) ? scr : ctl, d);
            chk_out();
        end
        for (i = 0; i < 4; i++) begin
            u_link_model.wr(tbl[i], 8'hff);
            u_link_model.rd(tbl[i], d);
            check8("masked", texp[i], d);
        end
        ctl = 8'h7e;
        chk_out();
        for (i = 0; i < 5; i++) begin
            u_link_model.wr(6'h1d, fen[i]);
            n = alt_cnt;
            flt = ~flt;
            repeat (4) @(negedge clk);
            check1("float_event", fexp[i], alt_cnt == n + 1);
            u_link_model.rd(6'h20, d);
            check1("float_status", flt, d[0]);
        end
        for (i = 0; i < 7; i++) begin
            u_link_model.wr(6'h1d, {2'b00, i[0], 5'h00});
            vend = i[1];
            sense = codes[i];
            n = alt_cnt;
            u_link_model.wr(6'h36 + 6'(i % 2), 8'h10);
            u_link_model.rd(6'h36, d);
            check1("go_busy", 1'b1, d[4]);
            repeat (CYC + 2) @(negedge clk);
            for (k = 0; k < 2; k++) begin
                u_link_model.rd(6'h20, d);
                check8("status_done", {1'b0, 1'b1, sense, 2'b00, flt}, d);
            end
            u_link_model.rd(6'h36, d);
            check8("conversion", {3'b000, 1'b0, 1'b1, sense}, d);
            u_link_model.rd(6'h20, d);
            check8("status_clear", {1'b0, 1'b0, sense, 2'b00, flt}, d);
            check1("done_event", i[1:0] != 2'b00, alt_cnt == n + 1);
        end
        for (i = 0; i < 4; i++) begin
            ctl = (i < 2) ? 8'h1c : 8'h68;
            {data0, plus} = 2'($random(seed));
            u_link_model.uart(ctl);
            repeat (2) @(negedge clk);
            chk_out();
        end
        complete_run();
    end
endmodule

// file: bench/link_model.sv
`timescale 1ns/1ps
module link_model (
    input  wire logic       clk_i,
    input  wire logic       rvalid_i,
    input  wire logic [7:0] rdata_i,
    output logic      [5:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            write_o,
    output logic            read_o,
    output logic            mode_o
);
    initial {addr_o, wdata_o, write_o, read_o, mode_o} = '0;
    // Released lines show the inverse so a stale address is never mistaken for a live one
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, write_o} = {a, d, 1'b1};
        @(negedge clk_i);
        {addr_o, wdata_o, write_o} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {addr_o, read_o} = {a, 1'b1};
        @(negedge clk_i);
        {addr_o, read_o} = {~a, 1'b0};
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask
    task automatic uart(input logic [7:0] c);
        @(negedge clk_i);
        mode_o = 1'b0;
        wr(6'h19, c);
        mode_o = 1'b1;
    endtask
endmodule

// file: design/carkit_control_registers.sv
`timescale 1ns/1ps
module carkit_control_registers #(
    parameter int CONVERT_CYCLES = carkit_pkg::CONVERT_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [5:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    input  wire logic       accessory_mode_select_i,
    input  wire logic       vendor_done_event_enable_i,
    input  wire logic       ulpi_data0_i,
    input  wire logic       plus_line_i,
    input  wire logic       id_pin_floating_i,
    input  wire logic [2:0] id_resistor_sense_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_rvalid_o,
    output logic            id_pin_ground_drive_b_o,
    output logic            minus_line_drive_b_o,
    output logic            minus_line_data_o,
    output logic            ulpi_data1_o,
    output logic            left_speaker_switch_o,
    output logic            right_speaker_switch_o,
    output logic            left_speaker_pin_o,
    output logic            right_speaker_pin_o,
    output logic            single_ended_rx_enable_o,
    output logic            alt_int_o
);
    logic [7:0] scratch_byte;
    logic [7:0] carkit_switch_control;
    logic [7:0] carkit_event_enable;
    logic [7:0] carkit_event_status;
    logic [7:0] convert_view;
    logic       id_float_q;
    logic       id_float_prev;
    logic       measure_busy;
    logic       resistor_measure_done;
    logic       done_rise;
    logic [2:0] id_resistor_result;
    logic       measure_go;
    logic       convert_read;
    logic       tx_route;
    logic       rx_route;
    logic       audio_any;
    logic       right_closed;
    logic       float_on_event;
    logic       float_off_event;
    logic       done_event;
    carkit_pkg::reg_op_t convert_op;

    // Scratch byte drives nothing; it is only stored and read back
    settable_reg #(
        .BASE (carkit_pkg::SCRATCH_BASE),
        .MASK (carkit_pkg::SCRATCH_MASK)
    ) u_scratch (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .write_i (reg_write_i),
        .addr_i  (reg_addr_i),
        .wdata_i (reg_wdata_i),
        .value_o (scratch_byte)
    );

    // Bits 0 and 7 are masked off, so writes cannot reach them and they read zero
    settable_reg #(
        .BASE (carkit_pkg::SWITCH_BASE),
        .MASK (carkit_pkg::SWITCH_MASK)
    ) u_switch (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .write_i (reg_write_i),
        .addr_i  (reg_addr_i),
        .wdata_i (reg_wdata_i),
        .value_o (carkit_switch_control)
    );

    // Unimplemented enable bits are masked, so they always read zero
    settable_reg #(
        .BASE (carkit_pkg::EVENT_EN_BASE),
        .MASK (carkit_pkg::EVENT_EN_MASK)
    ) u_enable (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .write_i (reg_write_i),
        .addr_i  (reg_addr_i),
        .wdata_i (reg_wdata_i),
        .value_o (carkit_event_enable)
    );

    // Only a one written or set into the go bit starts a conversion;
    // writing zero while busy cannot abort it
    assign convert_op = carkit_pkg::write_op(reg_addr_i, carkit_pkg::CONVERT_BASE);
    assign measure_go = reg_write_i && reg_wdata_i[carkit_pkg::VEND_GO_BIT]
                        && (convert_op == carkit_pkg::OP_LOAD || convert_op == carkit_pkg::OP_SET);
    assign convert_read = reg_read_i && carkit_pkg::in_group(reg_addr_i, carkit_pkg::CONVERT_BASE);

    // Conversion length is a parameter so a test can run a short one
    resistor_converter #(
        .CYCLES (CONVERT_CYCLES)
    ) u_converter (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .go_i         (measure_go),
        .done_clear_i (convert_read),
        .sense_i      (id_resistor_sense_i),
        .busy_o       (measure_busy),
        .done_o       (resistor_measure_done),
        .done_rise_o  (done_rise),
        .result_o     (id_resistor_result)
    );

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_float_q <= 1'b0;
        end else begin
            id_float_q <= id_pin_floating_i;
        end
    end

    // Resets low: a pin floating at reset gives one rise, masked as enables reset to zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_float_prev <= 1'b0;
        end else begin
            id_float_prev <= id_float_q;
        end
    end

    always_comb begin
        carkit_event_status = 8'h00;
        carkit_event_status[carkit_pkg::STAT_FLOAT_BIT] = id_float_q;
        carkit_event_status[carkit_pkg::STAT_RESULT_LSB +: 3] = id_resistor_result;
        carkit_event_status[carkit_pkg::STAT_DONE_BIT] = resistor_measure_done;
    end

    // Vendor view of the converter; its reserved bits 7 to 5 stay zero
    always_comb begin
        convert_view = 8'h00;
        convert_view[2:0] = id_resistor_result;
        convert_view[carkit_pkg::VEND_DONE_BIT] = resistor_measure_done;
        convert_view[carkit_pkg::VEND_GO_BIT] = measure_busy;
    end

    // Read data follows the read strobe by one cycle; unmapped offsets read zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_read_i;
        end
    end

    // Data holds between reads, so a slow sampler still sees the last answer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            if (reg_read_i) begin
                if (carkit_pkg::in_group(reg_addr_i, carkit_pkg::SCRATCH_BASE)) begin
                    reg_rdata_o <= scratch_byte;
                end else if (carkit_pkg::in_group(reg_addr_i, carkit_pkg::SWITCH_BASE)) begin
                    reg_rdata_o <= carkit_switch_control;
                end else if (carkit_pkg::in_group(reg_addr_i, carkit_pkg::EVENT_EN_BASE)) begin
                    reg_rdata_o <= carkit_event_enable;
                end else if (reg_addr_i == carkit_pkg::EVENT_STATUS_ADR) begin
                    reg_rdata_o <= carkit_event_status;
                end else if (carkit_pkg::in_group(reg_addr_i, carkit_pkg::CONVERT_BASE)) begin
                    reg_rdata_o <= convert_view;
                end else begin
                    reg_rdata_o <= 8'h00;
                end
            end
        end
    end

    assign tx_route     = carkit_switch_control[carkit_pkg::TX_ROUTE_BIT];
    assign rx_route     = carkit_switch_control[carkit_pkg::RX_ROUTE_BIT];
    assign right_closed = carkit_switch_control[carkit_pkg::RIGHT_SPK_BIT]
                          | carkit_switch_control[carkit_pkg::MIC_BIT];
    assign audio_any    = carkit_switch_control[carkit_pkg::LEFT_SPK_BIT] | right_closed;

    // Switch controls are level outputs, registered once; the ground enable is active low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_pin_ground_drive_b_o <= 1'b1;
        end else begin
            id_pin_ground_drive_b_o <= !carkit_switch_control[carkit_pkg::ID_GROUND_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left_speaker_switch_o <= 1'b0;
        end else begin
            left_speaker_switch_o <= carkit_switch_control[carkit_pkg::LEFT_SPK_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            right_speaker_switch_o <= 1'b0;
        end else begin
            right_speaker_switch_o <= right_closed;
        end
    end

    // Receivers stay off while audio is switched in, so speech is not read as line state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            single_ended_rx_enable_o <= 1'b1;
        end else begin
            single_ended_rx_enable_o <= !audio_any;
        end
    end

    // UART data paths add one clock of latency to each route
    // The minus line is a two-way pin: its enable is low while the block drives it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            minus_line_drive_b_o <= 1'b1;
        end else begin
            minus_line_drive_b_o <= !(accessory_mode_select_i && tx_route);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            minus_line_data_o <= 1'b0;
        end else begin
            minus_line_data_o <= tx_route ? ulpi_data0_i : 1'b0;
        end
    end

    // Line 1 idles high so the link never sees a false start bit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ulpi_data1_o <= 1'b1;
        end else begin
            ulpi_data1_o <= rx_route ? plus_line_i : 1'b1;
        end
    end

    // Speaker pins carry UART data only in accessory mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left_speaker_pin_o <= 1'b0;
        end else begin
            left_speaker_pin_o <= accessory_mode_select_i && tx_route
                                  && carkit_switch_control[carkit_pkg::LEFT_SPK_BIT]
                                  && ulpi_data0_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            right_speaker_pin_o <= 1'b0;
        end else begin
            right_speaker_pin_o <= accessory_mode_select_i && rx_route
                                   && right_closed && plus_line_i;
        end
    end

    // Edges come from the sampled copy, never from the raw pin
    assign float_on_event  = id_float_q && !id_float_prev
                             && carkit_event_enable[carkit_pkg::FLOAT_ON_BIT];
    assign float_off_event = !id_float_q && id_float_prev
                             && carkit_event_enable[carkit_pkg::FLOAT_OFF_BIT];
    assign done_event      = done_rise && (carkit_event_enable[carkit_pkg::DONE_EVENT_BIT]
                             || vendor_done_event_enable_i);

    // Each cycle with any event gives one high cycle; holding it for the link is left to the interface
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alt_int_o <= 1'b0;
        end else begin
            alt_int_o <= float_on_event || float_off_event || done_event;
        end
    end
endmodule

// file: design/carkit_pkg.sv
package carkit_pkg;

    localparam logic [5:0] SCRATCH_BASE     = 6'h16;
    localparam logic [5:0] SWITCH_BASE      = 6'h19;
    localparam logic [5:0] EVENT_EN_BASE    = 6'h1d;
    localparam logic [5:0] EVENT_STATUS_ADR = 6'h20;
    localparam logic [5:0] CONVERT_BASE     = 6'h36;

    localparam logic [5:0] SET_STEP   = 6'h01;
    localparam logic [5:0] CLEAR_STEP = 6'h02;

    localparam logic [7:0] SCRATCH_MASK  = 8'hff;
    localparam logic [7:0] SWITCH_MASK   = 8'h7e;
    localparam logic [7:0] EVENT_EN_MASK = 8'h23;
    localparam logic [7:0] RESET_VALUE   = 8'h00;

    localparam int ID_GROUND_BIT   = 1;
    localparam int TX_ROUTE_BIT    = 2;
    localparam int RX_ROUTE_BIT    = 3;
    localparam int LEFT_SPK_BIT    = 4;
    localparam int RIGHT_SPK_BIT   = 5;
    localparam int MIC_BIT         = 6;
    localparam int FLOAT_ON_BIT    = 0;
    localparam int FLOAT_OFF_BIT   = 1;
    localparam int DONE_EVENT_BIT  = 5;
    localparam int STAT_FLOAT_BIT  = 0;
    localparam int STAT_RESULT_LSB = 3;
    localparam int STAT_DONE_BIT   = 6;
    localparam int VEND_DONE_BIT   = 3;
    localparam int VEND_GO_BIT     = 4;

    localparam int CLK_PERIOD_NS   = 40;
    localparam int CONVERT_TIME_NS = 282000;
    localparam int CONVERT_CYCLES  = CONVERT_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_LOAD,
        OP_SET,
        OP_CLEAR
    } reg_op_t;

    // Decodes a write into load, set or clear for a register at base
    function automatic reg_op_t write_op(input logic [5:0] addr, input logic [5:0] base);
        if (addr == base) begin
            write_op = OP_LOAD;
        end else if (addr == 6'(base + SET_STEP)) begin
            write_op = OP_SET;
        end else if (addr == 6'(base + CLEAR_STEP)) begin
            write_op = OP_CLEAR;
        end else begin
            write_op = OP_NONE;
        end
    endfunction

    function automatic logic in_group(input logic [5:0] addr, input logic [5:0] base);
        in_group = (addr >= base) && (addr <= 6'(base + CLEAR_STEP));
    endfunction

endpackage

// file: design/resistor_converter.sv
`timescale 1ns/1ps
module resistor_converter #(
    parameter int CYCLES = carkit_pkg::CONVERT_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       go_i,
    input  wire logic       done_clear_i,
    input  wire logic [2:0] sense_i,
    output logic            busy_o,
    output logic            done_o,
    output logic            done_rise_o,
    output logic      [2:0] result_o
);
    logic [12:0] count;
    logic        finish;

    assign finish = busy_o && (count == 13'(CYCLES - 1));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
            count  <= 13'h0000;
        end else if (finish) begin
            busy_o <= 1'b0;
            count  <= 13'h0000;
        end else if (busy_o) begin
            count <= 13'(count + 13'h0001);
        end else if (go_i) begin
            busy_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_o <= 3'h0;
        end else if (finish) begin
            result_o <= sense_i;
        end
    end

    // A finishing conversion wins over a read clearing the flag
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o      <= 1'b0;
            done_rise_o <= 1'b0;
        end else begin
            done_rise_o <= finish && !done_o;
            if (finish) begin
                done_o <= 1'b1;
            end else if (done_clear_i) begin
                done_o <= 1'b0;
            end
        end
    end
endmodule

// file: design/settable_reg.sv
`timescale 1ns/1ps
module settable_reg #(
    parameter logic [5:0] BASE = 6'h00,
    parameter logic [7:0] MASK = 8'hff
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       write_i,
    input  wire logic [5:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] value_o
);
    carkit_pkg::reg_op_t op;

    assign op = carkit_pkg::write_op(addr_i, BASE);

    // Bits outside the mask never store, so they always read zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            value_o <= carkit_pkg::RESET_VALUE;
        end else if (write_i) begin
            unique case (op)
                carkit_pkg::OP_LOAD:  value_o <= wdata_i & MASK;
                carkit_pkg::OP_SET:   value_o <= (value_o | wdata_i) & MASK;
                carkit_pkg::OP_CLEAR: value_o <= value_o & ~wdata_i;
                carkit_pkg::OP_NONE:  value_o <= value_o;
            endcase
        end
    end
endmodule
